// *** bench/host_cmd_model.sv ***
// host side of the parameter link, one word per request
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
  input wire logic sys_clk,
  input wire logic [15:0] rsp_param,
  input wire logic [15:0] rsp_value,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_param,
  output logic [15:0] req_wdata
);
  initial begin
    req_valid = 0;
    req_write = 0;
    req_param = '0;
    req_wdata = '0;
  end
  task automatic xfer(input logic wr, input logic [15:0] p, input logic [15:0] d,
                      output logic [31:0] r);
    @(posedge sys_clk);
    #1;
    req_valid = 1;
    req_write = wr;
    req_param = p;
    req_wdata = d;
    @(posedge sys_clk);
    #1;
    r = {rsp_param, rsp_value};
    req_valid = 0;
    // released lines show junk, not a stale word
    req_param = ~p;
    req_wdata = ~d;
  endtask
endmodule // host_cmd_model
`default_nettype wire

// *** bench/laser_tec_parameter_map_sva.sv ***
// port-level checks of the laser/cooler parameter map
`timescale 1ns/1ps
`default_nettype none
module param_map_sva (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_param,
  input wire logic [15:0] req_wdata,
  input wire logic temp_protect,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_param,
  input wire logic [15:0] rsp_value,
  input wire logic save_pulse,
  input wire logic main_il_denied,
  input wire logic ntc_il_denied,
  input wire logic [15:0] cur_cal_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire rq = req_valid && clk_en;
  wire wd = rq && req_write && req_param == 16'h0700;
  rsp_next_a: assert property (rq |=> rsp_valid) else $error("no answer");
  // idle enabled edge clears the answer strobe
  rsp_once_a: assert property (!req_valid && clk_en |=> !rsp_valid) else $error("stray answer");
  unknown_zero_a: assert property (rq && req_param == 16'h0001 |=> rsp_param == 16'h0000 && rsp_value == 16'h0000) else $error("unknown not zero");
  power_bit_a: assert property (rq && !req_write && req_param == 16'h0700 |=> rsp_value[0] && rsp_param == 16'h0700) else $error("power bit low");
  allow_il_a: assert property (wd && req_wdata == 16'h1000 |=> !main_il_denied) else $error("interlock not allowed");
  deny_il_a: assert property (wd && req_wdata == 16'h2000 |=> main_il_denied) else $error("interlock not denied");
  ntc_deny_a: assert property (wd && req_wdata == 16'h4000 |=> ntc_il_denied) else $error("ntc not denied");
  ntc_allow_a: assert property (wd && req_wdata == 16'h8000 |=> !ntc_il_denied) else $error("ntc not allowed");
  cal_span_a: assert property (cur_cal_out >= 16'h251C && cur_cal_out <= 16'h2904) else $error("cal out of span");
  protect_lock_a: assert property (rq && !req_write && req_param == 16'h0800 && temp_protect |=> rsp_value[4]) else $error("protect flag missing");
  save_pulse_a: assert property (rq && req_write && req_param == 16'h0900 |=> save_pulse) else $error("no save pulse");
endmodule // param_map_sva
bind laser_tec_parameter_map param_map_sva u_sva (.*);
`default_nettype wire

// *** bench/test_laser_tec_parameter_map.sv ***
// self-checking bench of the laser/cooler parameter map
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module test_laser_tec_parameter_map;
  localparam logic [15:0] SER = 16'h5A3C; // arbitrary value
  logic sys_clk = 0;
  logic nrst = 0;
  logic clk_en = 1;
  logic [6:0] flt = 0;
  logic [15:0] mb = 0;
  logic [31:0] r;
  integer errors = 0, checked = 0, cyc = 0, i;
  wire req_valid, req_write, save_pulse, restore_pulse, main_il_denied, ntc_il_denied;
  wire [15:0] req_param, req_wdata, rsp_param, rsp_value, cur_cal_out, tec_cal_out;
  wire rsp_valid, drv_run, drv_int_set, drv_int_en, tec_run, tec_int_set, tec_int_en;
  wire [5:0] lvl = {drv_run, drv_int_set, drv_int_en, tec_run, tec_int_set, tec_int_en};
  logic [47:0] st [16] = '{48'h0700_1000_0055, 48'h0700_8000_0015, 48'h0700_4000_0055,
    48'h0700_2000_00D5, 48'h0700_0008_00D7, 48'h0700_0040_00D1, 48'h0700_0200_00C1,
    48'h0700_0008_00C1, 48'h0700_0400_00D1, 48'h0700_0020_00D5, 48'h0700_0010_00D5,
    48'h0A1A_0008_0016, 48'h0A1A_0040_0010, 48'h0A1A_0200_0000, 48'h0A1A_0400_0010,
    48'h0A1A_0020_0014};
  logic [47:0] cal [5] = '{48'h030E_0000_251C, 48'h030E_FFFF_2904, 48'h030E_2800_2800,
    48'h0A1E_251B_251C, 48'h0A1E_2905_2904};
  logic [15:0] rw [7] = '{16'h0A05, 16'h0A06, 16'h0A1F, 16'h0A21, 16'h0A22, 16'h0A23, 16'h0B0E};
  logic [15:0] ms [7] = '{16'h0307, 16'h0407, 16'h0308, 16'h0A15, 16'h0A16, 16'h0A18, 16'h0AE4};
  logic [55:0] lk = 56'h10_1080_4020_1008;
  host_cmd_model host (.sys_clk(sys_clk), .rsp_param(rsp_param), .rsp_value(rsp_value),
    .req_valid(req_valid), .req_write(req_write), .req_param(req_param), .req_wdata(req_wdata));
  laser_tec_parameter_map #(.SERIAL_NUMBER(SER)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(clk_en), .req_valid(req_valid), .req_write(req_write), .req_param(req_param),
    .req_wdata(req_wdata), .meas_current(mb ^ 16'h0307), .meas_voltage(mb ^ 16'h0407),
    .meas_cur_prot(mb ^ 16'h0308), .meas_tec_temp(mb ^ 16'h0A15),
    .meas_tec_current(mb ^ 16'h0A16), .meas_tec_voltage(mb ^ 16'h0A18),
    .meas_ext_temp(mb ^ 16'h0AE4), .temp_warning(flt[5]), .temp_protect(flt[6]),
    .fault_interlock(flt[0]), .fault_overcurrent(flt[1]), .fault_ntc(flt[2]),
    .fault_tec_error(flt[3]), .fault_tec_selfheat(flt[4]), .rsp_valid(rsp_valid),
    .rsp_param(rsp_param),
    .rsp_value(rsp_value), .save_pulse(save_pulse), .restore_pulse(restore_pulse),
    .drv_run(drv_run), .drv_int_set(drv_int_set), .drv_int_en(drv_int_en), .tec_run(tec_run),
    .tec_int_set(tec_int_set), .tec_int_en(tec_int_en),
    .main_il_denied(main_il_denied), .ntc_il_denied(ntc_il_denied),
    .cur_cal_out(cur_cal_out), .tec_cal_out(tec_cal_out));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish();
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, about two hundred cycles are expected
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1;
    host.xfer(0, 16'h0700, '0, r); `CHK(r, 32'h0700_00D5)
    `CHK(rsp_valid, 1'b1)
    host.xfer(0, 16'h0A1A, '0, r); `CHK(r[15:0] & 16'h0016, 16'h0014)
    host.xfer(0, 16'h030E, '0, r); `CHK(r[15:0], 16'h2710)
    host.xfer(0, 16'h0A1E, '0, r); `CHK(r[15:0], 16'h2710)
    for (i = 0; i < 16; i++) begin
      host.xfer(1, st[i][47:32], st[i][31:16], r);
      host.xfer(0, st[i][47:32], '0, r);
      `CHK(r[15:0] & (st[i][47:32] == 16'h0700 ? 16'hFFFF : 16'h0016), st[i][15:0])
      `CHK(st[i][47:32] == 16'h0700 ? lvl[5:3] : lvl[2:0], {st[i][1], st[i][2], st[i][4]})
    end
    `CHK({main_il_denied, ntc_il_denied}, 2'b11)
    for (i = 0; i < 5; i++) begin
      host.xfer(1, cal[i][47:32], cal[i][31:16], r);
      host.xfer(0, cal[i][47:32], '0, r);
      `CHK(r[15:0], cal[i][15:0])
    end
    `CHK({cur_cal_out, tec_cal_out}, 32'h2800_2904)
    for (i = 0; i < 7; i++) begin
      host.xfer(0, rw[i], '0, r); `CHK(r[15:0], 16'h0000)
      host.xfer(1, rw[i], rw[i] ^ 16'h5A5A, r);
      host.xfer(0, rw[i], '0, r); `CHK(r[15:0], rw[i] ^ 16'h5A5A)
    end
    for (i = 0; i < 7; i++) begin
      mb = i[15:0] * 16'h1111;
      host.xfer(1, ms[i], 16'hFFFF, r);
      host.xfer(0, ms[i], '0, r); `CHK(r, {ms[i], mb ^ ms[i]})
    end
    host.xfer(1, 16'h0701, '0, r);
    host.xfer(0, 16'h0701, '0, r); `CHK(r[15:0], SER)
    host.xfer(0, 16'h0001, '0, r); `CHK(r, 32'h0000_0000)
    host.xfer(1, 16'h0703, '0, r); `CHK(r, 32'h0000_0000)
    // lock flags one at a time
    for (i = 0; i < 7; i++) begin
      flt = 7'h01 << i;
      host.xfer(0, 16'h0800, '0, r); `CHK(r[7:0], lk[8*i +: 8])
    end
    flt = 0;
    // frozen while disabled
    clk_en = 0;
    host.xfer(1, 16'h0700, 16'h1000, r);
    clk_en = 1;
    host.xfer(0, 16'h0700, '0, r); `CHK(r[15:0], 16'h00D5)
    host.xfer(1, 16'h0900, '0, r); `CHK(save_pulse, 1'b1)
    host.xfer(1, 16'h0901, '0, r); `CHK(restore_pulse, 1'b1)
    @(posedge sys_clk);
    #1 `CHK({rsp_valid, restore_pulse}, 2'b00)
    tally_and_finish();
  end
endmodule // test_laser_tec_parameter_map
`default_nettype wire

// *** hw/laser_tec_parameter_map.v ***
// parameter map of a laser driver with cooler controller, word access port
// How it works
// - driver state bit 0 always reads one, the unit is powered.
// - bit 1 of both state masks reads one while that channel runs.
// - bits 2 and 4 read one for internal set-point and enable source.
// - driver bits 6 and 7 read one when ntc and main interlock are denied.
// - codes 1000h/2000h/4000h/8000h written to driver state set the interlocks.
// - one interlock setting serves both driver and cooler.
// - reaching the warning temperature sets the overheat lock flag.
// - in over-temperature protection overheat and overcurrent read set together.
// - calibration words step 0.01 percent and reset to 2710h.
// - calibration words are clamped between 251Ch and 2904h.
// - serial number is read-only and returns the unit number.
// - internal laser thermistor beta is read-write, one kelvin per count.
// - driver current and cooler have their own calibration words.
// - each value travels as a 16-bit word, four hex characters in the reply.
// - an unknown parameter number answers with parameter and value zero.
`timescale 1ns/1ps
`default_nettype none
`include "param_map.vh"
module laser_tec_parameter_map #(
  parameter [15:0] SERIAL_NUMBER = 16'h1234, // arbitrary value
  parameter [15:0] FREQ_MIN = 16'h0000,
  parameter [15:0] FREQ_MAX = 16'h0064,
  parameter [15:0] DUR_MIN = 16'h0014,
  parameter [15:0] DUR_MAX = 16'hC350,
  parameter [15:0] CUR_MIN = 16'h0000,
  parameter [15:0] CUR_MAX_LIM = 16'h1388,
  parameter [15:0] TEC_MAX_LIM = 16'h1388,
  parameter [15:0] TEC_MIN_LIM = 16'h01F4,
  parameter [15:0] WORD_RESET = 16'h0000
) (
  input wire sys_clk,
  input wire nrst,
  input wire clk_en,
  input wire req_valid,
  input wire req_write,
  input wire [15:0] req_param,
  input wire [15:0] req_wdata,
  input wire [15:0] meas_current,
  input wire [15:0] meas_voltage,
  input wire [15:0] meas_cur_prot,
  input wire [15:0] meas_tec_temp,
  input wire [15:0] meas_tec_current,
  input wire [15:0] meas_tec_voltage,
  input wire [15:0] meas_ext_temp,
  input wire temp_warning,
  input wire temp_protect,
  input wire fault_interlock,
  input wire fault_overcurrent,
  input wire fault_ntc,
  input wire fault_tec_error,
  input wire fault_tec_selfheat,
  output reg rsp_valid,
  output reg [15:0] rsp_param,
  output reg [15:0] rsp_value,
  output reg save_pulse,
  output reg restore_pulse,
  output reg drv_run,
  output reg drv_int_set,
  output reg drv_int_en,
  output reg tec_run,
  output reg tec_int_set,
  output reg tec_int_en,
  output reg main_il_denied,
  output reg ntc_il_denied,
  output reg [15:0] cur_cal_out,
  output reg [15:0] tec_cal_out
);

  // clamp into the calibration span
  function [15:0] clamp_cal;
    input [15:0] v;
    begin
      if (v < `CAL_MIN) begin
        clamp_cal = `CAL_MIN;
      end else if (v > `CAL_MAX) begin
        clamp_cal = `CAL_MAX;
      end else begin
        clamp_cal = v;
      end
    end
  endfunction

  // build a state mask from run and source bits
  function [15:0] state_mask;
    input run;
    input int_set;
    input int_en;
    begin
      state_mask = `WORD_ZERO;
      state_mask[`ST_RUN] = run;
      state_mask[`ST_SETSRC] = int_set;
      state_mask[`ST_ENSRC] = int_en;
    end
  endfunction

  reg [15:0] freq_q;
  reg [15:0] dur_q;
  reg [15:0] cur_set_q;
  reg [15:0] cur_max_q;
  reg [15:0] ext_lo_q;
  reg [15:0] ext_hi_q;
  reg [15:0] tec_set_q;
  reg [15:0] tec_max_q;
  reg [15:0] tec_min_q;
  reg [15:0] tec_cur_lim_q;
  reg [15:0] ld_beta_q;
  reg [15:0] ext_beta_q;
  reg [15:0] pid_p_q;
  reg [15:0] pid_i_q;
  reg [15:0] pid_d_q;

  reg [15:0] drv_mask;
  reg [15:0] tec_mask;
  reg [15:0] lock_mask;
  reg [15:0] rd_value;
  reg known;
  wire wr = req_valid & req_write;

  always @* begin
    drv_mask = state_mask(drv_run, drv_int_set, drv_int_en);
    drv_mask[`ST_POWER] = 1'b1;
    drv_mask[`ST_NTC_IL] = ntc_il_denied;
    drv_mask[`ST_MAIN_IL] = main_il_denied;
    tec_mask = state_mask(tec_run, tec_int_set, tec_int_en);
    lock_mask = `WORD_ZERO;
    lock_mask[`LK_IL] = fault_interlock;
    lock_mask[`LK_NTC] = fault_ntc;
    lock_mask[`LK_TEC_ERR] = fault_tec_error;
    lock_mask[`LK_TEC_HEAT] = fault_tec_selfheat;
    // overheat and overcurrent share bit 4
    lock_mask[`LK_OVERHEAT] = temp_warning | temp_protect | fault_overcurrent;
  end

  always @* begin
    known = 1'b1;
    rd_value = `WORD_ZERO;
    case (req_param)
      `P_PULSE_FREQ: rd_value = freq_q;
      `P_PULSE_FREQ_MIN: rd_value = FREQ_MIN;
      `P_PULSE_FREQ_MAX: rd_value = FREQ_MAX;
      `P_PULSE_DUR: rd_value = dur_q;
      `P_PULSE_DUR_MIN: rd_value = DUR_MIN;
      `P_PULSE_DUR_MAX: rd_value = DUR_MAX;
      `P_CUR_SET: rd_value = cur_set_q;
      `P_CUR_MIN: rd_value = CUR_MIN;
      `P_CUR_MAX: rd_value = cur_max_q;
      `P_CUR_MAX_LIM: rd_value = CUR_MAX_LIM;
      `P_CUR_MEAS: rd_value = meas_current;
      `P_CUR_PROT: rd_value = meas_cur_prot;
      `P_CUR_CAL: rd_value = cur_cal_out;
      `P_VOLT_MEAS: rd_value = meas_voltage;
      `P_DRV_STATE: rd_value = drv_mask;
      `P_SERIAL: rd_value = SERIAL_NUMBER;
      `P_LOCK: rd_value = lock_mask;
      `P_SAVE: rd_value = `WORD_ZERO;
      `P_RESTORE: rd_value = `WORD_ZERO;
      `P_EXT_LO: rd_value = ext_lo_q;
      `P_EXT_HI: rd_value = ext_hi_q;
      `P_TEC_SET: rd_value = tec_set_q;
      `P_TEC_MAX: rd_value = tec_max_q;
      `P_TEC_MIN: rd_value = tec_min_q;
      `P_TEC_MAX_LIM: rd_value = TEC_MAX_LIM;
      `P_TEC_MIN_LIM: rd_value = TEC_MIN_LIM;
      `P_TEC_MEAS: rd_value = meas_tec_temp;
      `P_TEC_CUR_MEAS: rd_value = meas_tec_current;
      `P_TEC_CUR_LIM: rd_value = tec_cur_lim_q;
      `P_TEC_VOLT: rd_value = meas_tec_voltage;
      `P_TEC_STATE: rd_value = tec_mask;
      `P_TEC_CAL: rd_value = tec_cal_out;
      `P_LD_BETA: rd_value = ld_beta_q;
      `P_PID_P: rd_value = pid_p_q;
      `P_PID_I: rd_value = pid_i_q;
      `P_PID_D: rd_value = pid_d_q;
      `P_EXT_MEAS: rd_value = meas_ext_temp;
      `P_EXT_BETA: rd_value = ext_beta_q;
      default: known = 1'b0;
    endcase
  end

  // next run and source bits of one channel after a state command
  function [2:0] next_state;
    input [15:0] code;
    input int_set;
    input int_en;
    reg run_n;
    reg set_n;
    reg en_n;
    begin
      // every code but start stops the channel, external enable blocks a start
      run_n = (code == `CMD_START) & int_en;
      set_n = int_set;
      en_n = int_en;
      // only exact codes act, a mix of codes only stops the channel
      if (code == `CMD_INT_SET) begin
        set_n = 1'b1;
      end
      if (code == `CMD_EXT_SET) begin
        set_n = 1'b0;
      end
      if (code == `CMD_INT_EN) begin
        en_n = 1'b1;
      end
      if (code == `CMD_EXT_EN) begin
        en_n = 1'b0;
      end
      next_state = {run_n, set_n, en_n};
    end
  endfunction

  always @(posedge sys_clk) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_param <= `WORD_ZERO;
      rsp_value <= `WORD_ZERO;
    end else if (clk_en) begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        // a write answers the value held before it
        // words hold until the next request
        rsp_param <= known ? req_param : `WORD_ZERO;
        rsp_value <= known ? rd_value : `WORD_ZERO;
      end
    end
  end

  // save and restore strobes
  // a read of these numbers strobes nothing
  always @(posedge sys_clk) begin
    if (!nrst) begin
      save_pulse <= 1'b0;
      restore_pulse <= 1'b0;
    end else if (clk_en) begin
      save_pulse <= wr & (req_param == `P_SAVE);
      restore_pulse <= wr & (req_param == `P_RESTORE);
    end
  end

  // laser words, no read-only arm
  // limits not enforced here, the interpreter owns them
  always @(posedge sys_clk) begin
    if (!nrst) begin
      freq_q <= WORD_RESET;
      dur_q <= WORD_RESET;
      cur_set_q <= WORD_RESET;
      cur_max_q <= WORD_RESET;
    end else if (clk_en && wr) begin
      case (req_param)
        `P_PULSE_FREQ: freq_q <= req_wdata;
        `P_PULSE_DUR: dur_q <= req_wdata;
        `P_CUR_SET: cur_set_q <= req_wdata;
        `P_CUR_MAX: cur_max_q <= req_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      ext_lo_q <= WORD_RESET;
      ext_hi_q <= WORD_RESET;
      ld_beta_q <= WORD_RESET;
      ext_beta_q <= WORD_RESET;
    end else if (clk_en && wr) begin
      case (req_param)
        `P_EXT_LO: ext_lo_q <= req_wdata;
        `P_EXT_HI: ext_hi_q <= req_wdata;
        `P_LD_BETA: ld_beta_q <= req_wdata;
        `P_EXT_BETA: ext_beta_q <= req_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      tec_set_q <= WORD_RESET;
      tec_max_q <= WORD_RESET;
      tec_min_q <= WORD_RESET;
      tec_cur_lim_q <= WORD_RESET;
      pid_p_q <= WORD_RESET;
      pid_i_q <= WORD_RESET;
      pid_d_q <= WORD_RESET;
    end else if (clk_en && wr) begin
      case (req_param)
        `P_TEC_SET: tec_set_q <= req_wdata;
        `P_TEC_MAX: tec_max_q <= req_wdata;
        `P_TEC_MIN: tec_min_q <= req_wdata;
        `P_TEC_CUR_LIM: tec_cur_lim_q <= req_wdata;
        `P_PID_P: pid_p_q <= req_wdata;
        `P_PID_I: pid_i_q <= req_wdata;
        `P_PID_D: pid_d_q <= req_wdata;
        default: ;
      endcase
    end
  end

  // clamped calibration words
  // out-of-span writes land on the nearest end
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cur_cal_out <= `CAL_DEFAULT;
      tec_cal_out <= `CAL_DEFAULT;
    end else if (clk_en && wr) begin
      if (req_param == `P_CUR_CAL) begin
        cur_cal_out <= clamp_cal(req_wdata);
      end
      if (req_param == `P_TEC_CAL) begin
        tec_cal_out <= clamp_cal(req_wdata);
      end
    end
  end

  // driver run bits
  // interlock codes land here too and stop the driver
  always @(posedge sys_clk) begin
    if (!nrst) begin
      drv_run <= 1'b0;
      drv_int_set <= 1'b1;
      drv_int_en <= 1'b1;
    end else if (clk_en && wr && (req_param == `P_DRV_STATE)) begin
      {drv_run, drv_int_set, drv_int_en} <= next_state(req_wdata, drv_int_set, drv_int_en);
    end
  end

  // cooler run bits
  // the cooler has no interlock codes of its own
  always @(posedge sys_clk) begin
    if (!nrst) begin
      tec_run <= 1'b0;
      tec_int_set <= 1'b1;
      tec_int_en <= 1'b1;
    end else if (clk_en && wr && (req_param == `P_TEC_STATE)) begin
      {tec_run, tec_int_set, tec_int_en} <= next_state(req_wdata, tec_int_set, tec_int_en);
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      // both interlocks start denied
      main_il_denied <= 1'b1;
      ntc_il_denied <= 1'b1;
    end else if (clk_en && wr && (req_param == `P_DRV_STATE)) begin
      case (req_wdata)
        `CMD_ALLOW_IL: begin
          main_il_denied <= 1'b0;
        end
        `CMD_DENY_IL: begin
          main_il_denied <= 1'b1;
        end
        `CMD_DENY_NTC: begin
          ntc_il_denied <= 1'b1;
        end
        `CMD_ALLOW_NTC: begin
          ntc_il_denied <= 1'b0;
        end
        default: ;
      endcase
    end
  end

endmodule // laser_tec_parameter_map
`default_nettype wire

// *** hw/param_map.vh ***
// parameter numbers, field positions and codes of the laser/cooler parameter map
`ifndef PARAM_MAP_MAP_VH
`define PARAM_MAP_MAP_VH
`define P_PULSE_FREQ 16'h0100
`define P_PULSE_FREQ_MIN 16'h0101
`define P_PULSE_FREQ_MAX 16'h0102
`define P_PULSE_DUR 16'h0200
`define P_PULSE_DUR_MIN 16'h0201
`define P_PULSE_DUR_MAX 16'h0202
`define P_CUR_SET 16'h0300
`define P_CUR_MIN 16'h0301
`define P_CUR_MAX 16'h0302
`define P_CUR_MAX_LIM 16'h0306
`define P_CUR_MEAS 16'h0307
`define P_CUR_PROT 16'h0308
`define P_CUR_CAL 16'h030E
`define P_VOLT_MEAS 16'h0407
`define P_DRV_STATE 16'h0700
`define P_SERIAL 16'h0701
`define P_LOCK 16'h0800
`define P_SAVE 16'h0900
`define P_RESTORE 16'h0901
`define P_EXT_LO 16'h0A05
`define P_EXT_HI 16'h0A06
`define P_TEC_SET 16'h0A10
`define P_TEC_MAX 16'h0A11
`define P_TEC_MIN 16'h0A12
`define P_TEC_MAX_LIM 16'h0A13
`define P_TEC_MIN_LIM 16'h0A14
`define P_TEC_MEAS 16'h0A15
`define P_TEC_CUR_MEAS 16'h0A16
`define P_TEC_CUR_LIM 16'h0A17
`define P_TEC_VOLT 16'h0A18
`define P_TEC_STATE 16'h0A1A
`define P_TEC_CAL 16'h0A1E
`define P_LD_BETA 16'h0A1F
`define P_PID_P 16'h0A21
`define P_PID_I 16'h0A22
`define P_PID_D 16'h0A23
`define P_EXT_MEAS 16'h0AE4
`define P_EXT_BETA 16'h0B0E
// state command codes
`define CMD_START 16'h0008
`define CMD_STOP 16'h0010
`define CMD_INT_SET 16'h0020
`define CMD_EXT_SET 16'h0040
`define CMD_EXT_EN 16'h0200
`define CMD_INT_EN 16'h0400
`define CMD_ALLOW_IL 16'h1000
`define CMD_DENY_IL 16'h2000
`define CMD_DENY_NTC 16'h4000
`define CMD_ALLOW_NTC 16'h8000
// state mask bit positions
`define ST_POWER 0
`define ST_RUN 1
`define ST_SETSRC 2
`define ST_ENSRC 4
`define ST_NTC_IL 6
`define ST_MAIN_IL 7
// lock status bit positions
`define LK_IL 3
`define LK_OVERCUR 4
`define LK_OVERHEAT 4
`define LK_NTC 5
`define LK_TEC_ERR 6
`define LK_TEC_HEAT 7
// calibration
`define CAL_DEFAULT 16'h2710
`define CAL_MIN 16'h251C
`define CAL_MAX 16'h2904
`define WORD_ZERO 16'h0000
`endif
